// ### design/msr_defines.vh
// Register offsets, reset values, field positions and store indices of the motion register bank.
// Assumes an 8-bit register space reached through a seven-bit serial address.
`ifndef MSR_DEFINES_VH
`define MSR_DEFINES_VH

// Register offsets
`define MSR_A_PRODUCT_ID      7'h00
`define MSR_A_REVISION_ID     7'h01
`define MSR_A_MOTION_STATUS   7'h02
`define MSR_A_X_DISP          7'h03
`define MSR_A_Y_DISP          7'h04
`define MSR_A_SURFACE_QUALITY 7'h05
`define MSR_A_SHUTTER_HIGH    7'h06
`define MSR_A_SHUTTER_LOW     7'h07
`define MSR_A_PIXEL_PEAK      7'h08
`define MSR_A_PIXEL_AVERAGE   7'h09
`define MSR_A_PIXEL_FLOOR     7'h0A
`define MSR_A_PIXEL_CAPTURE   7'h0B
`define MSR_A_SENSOR_CONTROL  7'h0D
`define MSR_A_RUN_REST1_DELAY 7'h0E
`define MSR_A_REST1_INTERVAL  7'h0F
`define MSR_A_REST1_2_DELAY   7'h10
`define MSR_A_REST2_INTERVAL  7'h11
`define MSR_A_REST2_3_DELAY   7'h12
`define MSR_A_REST3_INTERVAL  7'h13
`define MSR_A_WRITE_UNLOCK    7'h21
`define MSR_A_FRAME_GAP       7'h35
`define MSR_A_SOFT_RESET      7'h3A
`define MSR_A_INV_REVISION    7'h3F
`define MSR_A_LIGHT_SOURCE    7'h40
`define MSR_A_MOTION_OUTPUT   7'h41
`define MSR_A_BURST_START     7'h42
`define MSR_A_LIGHT_AUTO      7'h43
`define MSR_A_REST_CONFIG     7'h45
`define MSR_A_BURST_PORT      7'h63

// Reset values
`define MSR_R_ZERO            8'h00
`define MSR_R_SHUTTER_HIGH    8'h01
`define MSR_R_SENSOR_CONTROL  8'h01
`define MSR_R_RUN_REST1_DELAY 8'h46
`define MSR_R_REST1_2_DELAY   8'h4F
`define MSR_R_REST2_INTERVAL  8'h09
`define MSR_R_REST2_3_DELAY   8'h2F
`define MSR_R_REST3_INTERVAL  8'h31
`define MSR_R_FRAME_GAP       8'hF0
`define MSR_R_MOTION_OUTPUT   8'h40
`define MSR_R_BURST_START     8'h03
`define MSR_R_LIGHT_AUTO      8'h08

// Field positions and command values
`define MSR_F_MOTION_FLAG     7
`define MSR_F_WRITE_BIT       7
`define MSR_SOFT_RESET_KEY    8'h5A

// Configuration store indices
`define MSR_CFG_DEPTH         16
`define MSR_I_PIXEL_CAPTURE   4'h0
`define MSR_I_SENSOR_CONTROL  4'h1
`define MSR_I_RUN_REST1_DELAY 4'h2
`define MSR_I_REST1_INTERVAL  4'h3
`define MSR_I_REST1_2_DELAY   4'h4
`define MSR_I_REST2_INTERVAL  4'h5
`define MSR_I_REST2_3_DELAY   4'h6
`define MSR_I_REST3_INTERVAL  4'h7
`define MSR_I_FRAME_GAP       4'h8
`define MSR_I_LIGHT_SOURCE    4'h9
`define MSR_I_MOTION_OUTPUT   4'hA
`define MSR_I_BURST_START     4'hB
`define MSR_I_LIGHT_AUTO      4'hC
`define MSR_I_REST_CONFIG     4'hD

`endif

// ### design/msr_cfg_store.v
// Configuration store: sixteen byte entries with per-entry reset values.
// Assumes one write port and one read port on the same clock; read data registered.
`timescale 1ns/1ps
`default_nettype none
`include "msr_defines.vh"

module msr_cfg_store (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         soft_clr,
    input  wire         wr_en,
    input  wire [3:0]   wr_idx,
    input  wire [7:0]   wr_data,
    input  wire [3:0]   rd_idx,
    output reg  [7:0]   rd_data,
    output wire [127:0] all_q
);

    function [7:0] dflt;
        input integer idx;
        begin
            case (idx)
                `MSR_I_SENSOR_CONTROL:  dflt = `MSR_R_SENSOR_CONTROL;
                `MSR_I_RUN_REST1_DELAY: dflt = `MSR_R_RUN_REST1_DELAY;
                `MSR_I_REST1_2_DELAY:   dflt = `MSR_R_REST1_2_DELAY;
                `MSR_I_REST2_INTERVAL:  dflt = `MSR_R_REST2_INTERVAL;
                `MSR_I_REST2_3_DELAY:   dflt = `MSR_R_REST2_3_DELAY;
                `MSR_I_REST3_INTERVAL:  dflt = `MSR_R_REST3_INTERVAL;
                `MSR_I_FRAME_GAP:       dflt = `MSR_R_FRAME_GAP;
                `MSR_I_MOTION_OUTPUT:   dflt = `MSR_R_MOTION_OUTPUT;
                `MSR_I_BURST_START:     dflt = `MSR_R_BURST_START;
                `MSR_I_LIGHT_AUTO:      dflt = `MSR_R_LIGHT_AUTO;
                default:                dflt = `MSR_R_ZERO;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `MSR_CFG_DEPTH; g = g + 1) begin : ent
            reg [7:0] q;
            // Entries keep host values until a reset of either kind
            always @(posedge clk) begin
                if (!rst_n || soft_clr) begin
                    q <= dflt(g);
                end else if (wr_en && wr_idx == g) begin
                    q <= wr_data;
                end
            end
            assign all_q[g*8 +: 8] = q;
        end
    endgenerate

    always @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= `MSR_R_ZERO;
        end else begin
            rd_data <= all_q[rd_idx*8 +: 8];
        end
    end

endmodule // msr_cfg_store

`default_nettype wire

// ### design/msr_register_bank.v
// Motion sensor register bank behind a four-wire serial port.
// Assumes serial pins come from another domain and frame results arrive on clk.
//
// Overview of operation
// [RL1] Every register reachable by seven-bit serial address
// [RL2] Status read-only; configuration kept until reset
// [RL3] Motion flag in bit 7, rest zero
// [RL4] Shutter time split high/low, read-only
// [RL5] Burst start selector, default X displacement
// [RL6] Write-unlock register write-only, reads zero
// [RL7] Motion flag set on motion, cleared by X read or status write
// [RL8] X then Y reads stay coherent
// [RL9] Writing 5A to soft reset resets all
// [RL10] Burst port read streams registers from start
// [RL11] Writes to read-only addresses ignored; a write to status still clears the motion flag and X/Y counts
`timescale 1ns/1ps
`default_nettype none
`include "msr_defines.vh"

module msr_register_bank #(
    parameter [7:0] PRODUCT_CODE  = 8'h5C, // Arbitrary value
    parameter [7:0] REVISION_CODE = 8'h03  // Arbitrary value
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        sclk,
    input  wire        mosi,
    input  wire        ncs_n,
    output reg         miso,
    output reg         miso_oe,
    input  wire        frame_done,
    input  wire [7:0]  frame_dx,
    input  wire [7:0]  frame_dy,
    input  wire [7:0]  frame_quality,
    input  wire [15:0] frame_shutter,
    input  wire [7:0]  frame_peak,
    input  wire [7:0]  frame_pix_avg,
    input  wire [7:0]  frame_floor,
    output reg         motion_pending,
    output reg  [7:0]  write_unlock,
    output reg  [7:0]  sensor_control,
    output reg  [7:0]  light_source_control,
    output reg  [7:0]  motion_output_control,
    output reg  [7:0]  frame_gap_setting
);

    // Pin synchronisers
    reg        sclk_m;
    reg        sclk_s;
    reg        sclk_d;
    reg        mosi_m;
    reg        mosi_s;
    reg        ncs_m;
    reg        ncs_s;

    // Serial engine
    reg  [2:0] bit_cnt;
    reg  [6:0] shift_in;
    reg        data_phase;
    reg        is_write;
    reg  [6:0] cmd_addr;
    reg        burst_on;
    reg  [6:0] rd_addr;
    reg        rd_go;
    reg        rd_s1;
    reg        rd_s2;
    reg  [7:0] out_sh;
    reg        wr_go;
    reg  [7:0] wr_data;
    reg        soft_q;

    // Motion and frame statistics
    reg  [7:0] acc_x;
    reg  [7:0] acc_y;
    reg  [7:0] snap_x;
    reg  [7:0] snap_y;
    reg        motion_flag;
    reg  [7:0] surface_quality;
    reg  [7:0] shutter_time_high;
    reg  [7:0] shutter_time_low;
    reg  [7:0] pixel_peak;
    reg  [7:0] pixel_average;
    reg  [7:0] pixel_floor;

    wire         clr;
    wire         sclk_rise;
    wire         sclk_fall;
    wire         port_active;
    wire [7:0]   byte_in;
    wire [4:0]   rd_cfg;
    wire [4:0]   wr_cfg;
    wire [7:0]   cfg_rdata;
    wire [127:0] cfg_all;
    wire         snapshot;
    wire         status_wr;
    wire         new_motion;
    reg  [7:0]   read_value;

    assign clr         = !rst_n || soft_q;
    assign sclk_rise   = sclk_s && !sclk_d;
    assign sclk_fall   = !sclk_s && sclk_d;
    assign port_active = !ncs_s;
    assign byte_in     = {shift_in, mosi_s};

    // Maps an address to {valid, store index}
    function [4:0] cfg_index;
        input [6:0] a;
        begin
            case (a)
                `MSR_A_PIXEL_CAPTURE:   cfg_index = {1'b1, `MSR_I_PIXEL_CAPTURE};
                `MSR_A_SENSOR_CONTROL:  cfg_index = {1'b1, `MSR_I_SENSOR_CONTROL};
                `MSR_A_RUN_REST1_DELAY: cfg_index = {1'b1, `MSR_I_RUN_REST1_DELAY};
                `MSR_A_REST1_INTERVAL:  cfg_index = {1'b1, `MSR_I_REST1_INTERVAL};
                `MSR_A_REST1_2_DELAY:   cfg_index = {1'b1, `MSR_I_REST1_2_DELAY};
                `MSR_A_REST2_INTERVAL:  cfg_index = {1'b1, `MSR_I_REST2_INTERVAL};
                `MSR_A_REST2_3_DELAY:   cfg_index = {1'b1, `MSR_I_REST2_3_DELAY};
                `MSR_A_REST3_INTERVAL:  cfg_index = {1'b1, `MSR_I_REST3_INTERVAL};
                `MSR_A_FRAME_GAP:       cfg_index = {1'b1, `MSR_I_FRAME_GAP};
                `MSR_A_LIGHT_SOURCE:    cfg_index = {1'b1, `MSR_I_LIGHT_SOURCE};
                `MSR_A_MOTION_OUTPUT:   cfg_index = {1'b1, `MSR_I_MOTION_OUTPUT};
                `MSR_A_BURST_START:     cfg_index = {1'b1, `MSR_I_BURST_START};
                `MSR_A_LIGHT_AUTO:      cfg_index = {1'b1, `MSR_I_LIGHT_AUTO};
                `MSR_A_REST_CONFIG:     cfg_index = {1'b1, `MSR_I_REST_CONFIG};
                default:                cfg_index = 5'h00;
            endcase
        end
    endfunction

    // Signed add that clips instead of wrapping
    function [7:0] sat_add;
        input [7:0] a;
        input [7:0] b;
        reg   [8:0] s;
        begin
            s = {a[7], a} + {b[7], b};
            if (s[8] != s[7]) begin
                sat_add = s[8] ? 8'h80 : 8'h7F;
            end else begin
                sat_add = s[7:0];
            end
        end
    endfunction

    assign rd_cfg = cfg_index(rd_addr);
    assign wr_cfg = cfg_index(cmd_addr);

    msr_cfg_store u_store (
        .clk      (clk),
        .rst_n    (rst_n),
        .soft_clr (soft_q),
        .wr_en    (wr_go && wr_cfg[4]),
        .wr_idx   (wr_cfg[3:0]),
        .wr_data  (wr_data),
        .rd_idx   (rd_cfg[3:0]),
        .rd_data  (cfg_rdata),
        .all_q    (cfg_all)
    );

    // Two flops on every pin before use
    always @(posedge clk) begin
        if (!rst_n) begin
            sclk_m <= 1'b1;
            sclk_s <= 1'b1;
            sclk_d <= 1'b1;
            mosi_m <= 1'b0;
            mosi_s <= 1'b0;
            ncs_m  <= 1'b1;
            ncs_s  <= 1'b1;
        end else begin
            sclk_m <= sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            mosi_m <= mosi;
            mosi_s <= mosi_m;
            ncs_m  <= ncs_n;
            ncs_s  <= ncs_m;
        end
    end

    // [RL1] Address byte decode
    always @(posedge clk) begin
        if (clr) begin
            bit_cnt    <= 3'd0;
            shift_in   <= 7'h00;
            data_phase <= 1'b0;
            is_write   <= 1'b0;
            cmd_addr   <= 7'h00;
            burst_on   <= 1'b0;
            rd_addr    <= 7'h00;
            rd_go      <= 1'b0;
            wr_go      <= 1'b0;
            wr_data    <= 8'h00;
        end else begin
            rd_go <= 1'b0;
            wr_go <= 1'b0;
            if (!port_active) begin
                // Raising the select ends any command or burst
                bit_cnt    <= 3'd0;
                data_phase <= 1'b0;
                burst_on   <= 1'b0;
            end else if (sclk_rise) begin
                shift_in <= byte_in[6:0];
                bit_cnt  <= bit_cnt + 3'd1;
                if (bit_cnt == 3'd7) begin
                    if (!data_phase) begin
                        cmd_addr   <= byte_in[6:0];
                        is_write   <= byte_in[`MSR_F_WRITE_BIT];
                        data_phase <= 1'b1;
                        if (!byte_in[`MSR_F_WRITE_BIT]) begin
                            rd_go <= 1'b1;
                            // [RL5] [RL10] Burst begins at selector
                            if (byte_in[6:0] == `MSR_A_BURST_PORT) begin
                                burst_on <= 1'b1;
                                rd_addr  <= cfg_all[`MSR_I_BURST_START*8 +: 7];
                            end else begin
                                rd_addr <= byte_in[6:0];
                            end
                        end
                    end else if (burst_on) begin
                        // [RL10] Next register, no address
                        rd_addr <= rd_addr + 7'd1;
                        rd_go   <= 1'b1;
                    end else begin
                        data_phase <= 1'b0;
                        if (is_write) begin
                            wr_go   <= 1'b1;
                            wr_data <= byte_in;
                        end
                    end
                end
            end
        end
    end

    // [RL9] Soft reset key
    always @(posedge clk) begin
        if (!rst_n) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= wr_go && cmd_addr == `MSR_A_SOFT_RESET && wr_data == `MSR_SOFT_RESET_KEY;
        end
    end

    // [RL6] Unlock stored, never read back
    always @(posedge clk) begin
        if (clr) begin
            write_unlock <= `MSR_R_ZERO;
        end else if (wr_go && cmd_addr == `MSR_A_WRITE_UNLOCK) begin
            write_unlock <= wr_data;
        end
    end

    // [RL8] Snapshot taken when X is fetched
    assign snapshot   = rd_s1 && rd_addr == `MSR_A_X_DISP;
    assign status_wr  = wr_go && cmd_addr == `MSR_A_MOTION_STATUS;
    assign new_motion = frame_done && (frame_dx != 8'h00 || frame_dy != 8'h00);

    always @(posedge clk) begin
        if (clr || status_wr) begin
            acc_x  <= `MSR_R_ZERO;
            acc_y  <= `MSR_R_ZERO;
            snap_x <= `MSR_R_ZERO;
            snap_y <= `MSR_R_ZERO;
        end else if (snapshot) begin
            // New frame motion lands in the emptied accumulator
            snap_x <= acc_x;
            snap_y <= acc_y;
            acc_x  <= frame_done ? frame_dx : 8'h00;
            acc_y  <= frame_done ? frame_dy : 8'h00;
        end else if (frame_done) begin
            acc_x <= sat_add(acc_x, frame_dx);
            acc_y <= sat_add(acc_y, frame_dy);
        end
    end

    // [RL7] Set wins over report clear
    always @(posedge clk) begin
        if (clr) begin
            motion_flag <= 1'b0;
        end else if (new_motion) begin
            motion_flag <= 1'b1;
        end else if (snapshot || status_wr) begin
            motion_flag <= 1'b0;
        end
    end

    // [RL4] Frame statistics, host cannot write
    always @(posedge clk) begin
        if (clr) begin
            surface_quality   <= `MSR_R_ZERO;
            shutter_time_high <= `MSR_R_SHUTTER_HIGH;
            shutter_time_low  <= `MSR_R_ZERO;
            pixel_peak        <= `MSR_R_ZERO;
            pixel_average     <= `MSR_R_ZERO;
            pixel_floor       <= `MSR_R_ZERO;
        end else if (frame_done) begin
            surface_quality   <= frame_quality;
            shutter_time_high <= frame_shutter[15:8];
            shutter_time_low  <= frame_shutter[7:0];
            pixel_peak        <= frame_peak;
            pixel_average     <= frame_pix_avg;
            pixel_floor       <= frame_floor;
        end
    end

    // [RL2] Read value selection
    always @* begin
        read_value = 8'h00;
        if (rd_cfg[4]) begin
            read_value = cfg_rdata;
        end else begin
            case (rd_addr)
                `MSR_A_PRODUCT_ID:      read_value = PRODUCT_CODE;
                `MSR_A_REVISION_ID:     read_value = REVISION_CODE;
                // [RL3] Flag in top bit only
                `MSR_A_MOTION_STATUS:   read_value = {motion_flag, 7'h00};
                `MSR_A_X_DISP:          read_value = snap_x;
                `MSR_A_Y_DISP:          read_value = snap_y;
                `MSR_A_SURFACE_QUALITY: read_value = surface_quality;
                `MSR_A_SHUTTER_HIGH:    read_value = shutter_time_high;
                `MSR_A_SHUTTER_LOW:     read_value = shutter_time_low;
                `MSR_A_PIXEL_PEAK:      read_value = pixel_peak;
                `MSR_A_PIXEL_AVERAGE:   read_value = pixel_average;
                `MSR_A_PIXEL_FLOOR:     read_value = pixel_floor;
                `MSR_A_INV_REVISION:    read_value = ~REVISION_CODE;
                default:                read_value = 8'h00;
            endcase
        end
    end

    // Read pipeline: three clocks, one clock short of half an SCLK period
    always @(posedge clk) begin
        if (clr) begin
            rd_s1   <= 1'b0;
            rd_s2   <= 1'b0;
            out_sh  <= 8'h00;
            miso    <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            rd_s1   <= rd_go;
            rd_s2   <= rd_s1;
            miso_oe <= port_active;
            if (rd_s2) begin
                out_sh <= read_value;
            end else if (port_active && sclk_fall && data_phase && !is_write) begin
                miso   <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
            if (!port_active) begin
                miso <= 1'b0;
            end
        end
    end

    // [RL11] Only mapped writable entries reach outputs
    always @(posedge clk) begin
        if (clr) begin
            motion_pending        <= 1'b0;
            sensor_control        <= `MSR_R_SENSOR_CONTROL;
            light_source_control  <= `MSR_R_ZERO;
            motion_output_control <= `MSR_R_MOTION_OUTPUT;
            frame_gap_setting     <= `MSR_R_FRAME_GAP;
        end else begin
            motion_pending        <= motion_flag;
            sensor_control        <= cfg_all[`MSR_I_SENSOR_CONTROL*8 +: 8];
            light_source_control  <= cfg_all[`MSR_I_LIGHT_SOURCE*8 +: 8];
            motion_output_control <= cfg_all[`MSR_I_MOTION_OUTPUT*8 +: 8];
            frame_gap_setting     <= cfg_all[`MSR_I_FRAME_GAP*8 +: 8];
        end
    end

endmodule // msr_register_bank

`default_nettype wire

// ### test/msr_register_bank_assertions.sv
// Port checker for the motion register bank.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module msr_register_bank_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sclk,
    input wire logic       ncs_n,
    input wire logic       miso,
    input wire logic       miso_oe,
    input wire logic       frame_done,
    input wire logic [7:0] frame_dx,
    input wire logic [7:0] frame_dy,
    input wire logic       motion_pending,
    input wire logic [7:0] write_unlock,
    input wire logic [7:0] sensor_control,
    input wire logic [7:0] light_source_control,
    input wire logic [7:0] motion_output_control,
    input wire logic [7:0] frame_gap_setting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_idle_quiet: assert property (ncs_n [*6] |-> !miso && !miso_oe)
        else $error("serial output active while deselected");
    chk_select_drives: assert property (!ncs_n [*6] |-> miso_oe)
        else $error("output enable missing while selected");
    chk_reset_defaults: assert property ($rose(rst_n) |->
        sensor_control == 8'h01 && light_source_control == 8'h00 && motion_output_control == 8'h40
        && frame_gap_setting == 8'hF0 && write_unlock == 8'h00 && !motion_pending && !miso)
        else $error("outputs not at defaults after reset");
    chk_motion_sets: assert property (frame_done && (frame_dx != 8'h00 || frame_dy != 8'h00) |->
        ##[1:3] motion_pending)
        else $error("motion not flagged after moving frame");
    chk_motion_cause: assert property ($rose(motion_pending) |->
        $past(frame_done, 2) || $past(frame_done, 3))
        else $error("motion flagged without a frame");
    chk_motion_holds: assert property (ncs_n [*6] ##0 motion_pending |=> motion_pending)
        else $error("motion flag lost without host access");
    chk_cfg_stable: assert property (ncs_n [*6] |=> $stable(sensor_control)
        && $stable(light_source_control) && $stable(motion_output_control)
        && $stable(frame_gap_setting) && $stable(write_unlock))
        else $error("configuration changed while deselected");
    chk_miso_hold: assert property ((!ncs_n && sclk) [*2] |=> $stable(miso))
        else $error("serial output changed while clock high");
endmodule // msr_register_bank_assertions

bind msr_register_bank msr_register_bank_assertions chk_u (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .ncs_n(ncs_n), .miso(miso), .miso_oe(miso_oe),
    .frame_done(frame_done), .frame_dx(frame_dx), .frame_dy(frame_dy), .motion_pending(motion_pending),
    .write_unlock(write_unlock), .sensor_control(sensor_control), .light_source_control(light_source_control),
    .motion_output_control(motion_output_control), .frame_gap_setting(frame_gap_setting));
`default_nettype wire

// ### test/msr_host_model.sv
// Host side of the four-wire serial port.
// Assumes the caller is on clk; serial clock period is eight clk cycles.
`timescale 1ns/1ps
`default_nettype none
module msr_host_model (
    input  wire logic clk,
    input  wire logic miso,
    output var  logic sclk,
    output var  logic mosi,
    output var  logic ncs_n
);
    logic [7:0] rx_q [8];

    initial begin
        sclk = 1'b1;
        mosi = 1'b0;
        ncs_n = 1'b1;
    end

    // First byte then nbytes-1 wdata bytes; replies in rx_q
    task automatic frame(input logic [7:0] first, input logic [7:0] wdata, input int nbytes);
        logic [7:0] tx;
        logic [7:0] rx;
        @(posedge clk);
        ncs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int b = 0; b < nbytes; b++) begin
            tx = (b == 0) ? first : wdata;
            for (int i = 7; i >= 0; i--) begin
                sclk <= 1'b0;
                mosi <= tx[i];
                repeat (4) @(posedge clk);
                sclk <= 1'b1;
                repeat (4) @(posedge clk);
                // Bit stands until the next fall
                rx[i] = miso;
            end
            rx_q[b] = rx;
        end
        ncs_n <= 1'b1;
        // Released line must not look like a held value
        mosi <= ~mosi;
        repeat (8) @(posedge clk);
    endtask
endmodule // msr_host_model
`default_nettype wire

// ### test/tb_msr_register_bank.sv
// Self-checking bench for the motion register bank.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_msr_register_bank;
    localparam logic [7:0] PROD_CODE = 8'hA7; // Arbitrary value
    localparam logic [7:0] REV_CODE  = 8'h12; // Arbitrary value
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        frame_done = 1'b0;
    logic [7:0]  frame_dx = 8'h00, frame_dy = 8'h00, frame_quality = 8'h00;
    logic [7:0]  frame_peak = 8'h00, frame_pix_avg = 8'h00, frame_floor = 8'h00;
    logic [15:0] frame_shutter = 16'h0000;
    wire logic   sclk, mosi, ncs_n, miso, miso_oe, motion_pending;
    wire logic [7:0] write_unlock, sensor_control, light_source_control, motion_output_control, frame_gap_setting;
    int          num_errors = 0;
    int          num_checks = 0;

    always #50 clk = ~clk;

    msr_register_bank #(.PRODUCT_CODE(PROD_CODE), .REVISION_CODE(REV_CODE)) dut_u (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n), .miso(miso), .miso_oe(miso_oe),
        .frame_done(frame_done), .frame_dx(frame_dx), .frame_dy(frame_dy), .frame_quality(frame_quality),
        .frame_shutter(frame_shutter), .frame_peak(frame_peak), .frame_pix_avg(frame_pix_avg),
        .frame_floor(frame_floor), .motion_pending(motion_pending), .write_unlock(write_unlock),
        .sensor_control(sensor_control), .light_source_control(light_source_control),
        .motion_output_control(motion_output_control), .frame_gap_setting(frame_gap_setting));

    msr_host_model host_u (.clk(clk), .miso(miso), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n));

    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.frame({1'b1, a[6:0]}, d, 2);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.frame({1'b0, a[6:0]}, 8'h00, 2);
        chk(host_u.rx_q[1], exp);
    endtask

    task automatic chk_ports(input logic [7:0] sc, input logic [7:0] ls, input logic [7:0] mo,
                             input logic [7:0] fg, input logic [7:0] wu);
        chk(sensor_control, sc);
        chk(light_source_control, ls);
        chk(motion_output_control, mo);
        chk(frame_gap_setting, fg);
        chk(write_unlock, wu);
    endtask

    // Statistics follow the stat byte s so every register differs
    task automatic new_frame(input logic [7:0] dx, input logic [7:0] dy, input logic [7:0] s);
        @(posedge clk);
        frame_done <= 1'b1;
        frame_dx <= dx;
        frame_dy <= dy;
        frame_quality <= s;
        frame_shutter <= {s + 8'h01, s + 8'h02};
        frame_peak <= s + 8'h03;
        frame_pix_avg <= s + 8'h04;
        frame_floor <= s + 8'h05;
        @(posedge clk);
        frame_done <= 1'b0;
        for (int k = 0; k < 10 && motion_pending !== 1'b1; k++) @(posedge clk);
        if (motion_pending !== 1'b1) begin
            num_errors++;
            results;
        end
    endtask

    task automatic t_defaults;
        logic [15:0] tbl [29] = '{{8'h00, PROD_CODE}, {8'h01, REV_CODE}, {8'h3F, ~REV_CODE}, 16'h0200,
            16'h0300, 16'h0400, 16'h0500, 16'h0601, 16'h0700, 16'h0800, 16'h0900, 16'h0A00, 16'h0B00,
            16'h0C00, 16'h0D01, 16'h0E46, 16'h0F00, 16'h104F, 16'h1109, 16'h122F, 16'h1331, 16'h2100,
            16'h35F0, 16'h3A00, 16'h4000, 16'h4140, 16'h4203, 16'h4308, 16'h4500};
        foreach (tbl[i]) rd_chk(tbl[i][15:8], tbl[i][7:0]);
    endtask

    task automatic t_config;
        logic [7:0]  rw [13] = '{8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h35, 8'h40,
            8'h41, 8'h43, 8'h45};
        logic [15:0] ro [5] = '{{8'h00, PROD_CODE}, 16'h0300, 16'h0500, 16'h0601, {8'h3F, ~REV_CODE}};
        foreach (rw[i]) wr(rw[i], rw[i] + 8'h70);
        foreach (ro[i]) wr(ro[i][15:8], 8'hEE);
        wr(8'h21, 8'hC3);
        wr(8'h0C, 8'h99);
        chk_ports(8'h7D, 8'hB0, 8'hB1, 8'hA5, 8'hC3);
        foreach (rw[i]) rd_chk(rw[i], rw[i] + 8'h70);
        foreach (ro[i]) rd_chk(ro[i][15:8], ro[i][7:0]);
        rd_chk(8'h21, 8'h00);
        rd_chk(8'h0C, 8'h00);
    endtask

    task automatic t_motion;
        new_frame(8'h03, 8'hFF, 8'h10);
        new_frame(8'h04, 8'hFE, 8'h20);
        chk({7'h00, motion_pending}, 8'h01);
        rd_chk(8'h02, 8'h80);
        rd_chk(8'h03, 8'h07);
        rd_chk(8'h02, 8'h00);
        new_frame(8'h01, 8'h01, 8'h30);
        rd_chk(8'h04, 8'hFD);
        rd_chk(8'h02, 8'h80);
        for (int i = 0; i < 6; i++) rd_chk(8'h05 + 8'(i), 8'h30 + 8'(i));
        wr(8'h02, 8'h00);
        rd_chk(8'h02, 8'h00);
        chk({7'h00, motion_pending}, 8'h00);
    endtask

    task automatic t_burst;
        logic [7:0] exp [7] = '{8'h11, 8'h22, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
        wr(8'h02, 8'h00);
        new_frame(8'h11, 8'h22, 8'h40);
        host_u.frame(8'h63, 8'h00, 8);
        foreach (exp[i]) chk(host_u.rx_q[i + 1], exp[i]);
        wr(8'h42, 8'h05);
        rd_chk(8'h42, 8'h05);
        host_u.frame(8'h63, 8'h00, 4);
        for (int i = 1; i < 4; i++) chk(host_u.rx_q[i], exp[i + 1]);
    endtask

    task automatic t_soft_reset;
        wr(8'h3A, 8'hA5);
        chk_ports(8'h7D, 8'hB0, 8'hB1, 8'hA5, 8'hC3);
        wr(8'h3A, 8'h5A);
        chk_ports(8'h01, 8'h00, 8'h40, 8'hF0, 8'h00);
        chk({7'h00, motion_pending}, 8'h00);
        rd_chk(8'h42, 8'h03);
        rd_chk(8'h0E, 8'h46);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk_ports(8'h01, 8'h00, 8'h40, 8'hF0, 8'h00);
        t_defaults;
        t_config;
        t_motion;
        t_burst;
        t_soft_reset;
        results;
    end

    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        results;
    end
endmodule // tb_msr_register_bank
`default_nettype wire
